// File: hw/asp_pkg.sv
// Constants, field layout and state types for the serial port with IR endec
//
// Summary of operation
// - Free-running divider makes x16 and IR low-power ticks
// - Transmit queue holds 32 bytes until sent
// - Receive queue holds 32 twelve-bit entries until read
// - Queue disable turns both paths into one-byte holders
// - Frame: start, data LSB first, parity, stops
// - Receive after valid start; record overrun, parity, framing, break
// - Separate maskable active-high interrupt outputs
// - Combined interrupt is OR of individual ones
// - Test mode reads all inputs, writes all outputs
// - IR encoder sends one pulse per zero bit
// - Normal IR pulse lasts three x16 ticks
// - Low-power IR pulse lasts three divided ticks
// - IR output rests low, pulses high for zeros
// - IR input idles high; low marks start bit
// - Decoder drops pulses under three sixteenths tick
// - IR output polarity opposite to IR input
// - Fractional divide jitter stays within one clock
// - Bus decode reaches registers and both queues
// - IR on: serial out high, serial in ignored, half-duplex
// - Sample mid start at 8 or 4, then every 16
// - Entry: data 7:0, frame 8, parity 9, break 10, overrun 11
package asp_pkg;

	// Register addresses
	localparam logic [5:0] A_DATA  = 6'h00;
	localparam logic [5:0] A_STAT  = 6'h04;
	localparam logic [5:0] A_DIVI  = 6'h08;
	localparam logic [5:0] A_DIVF  = 6'h0C;
	localparam logic [5:0] A_LINE  = 6'h10;
	localparam logic [5:0] A_CTRL  = 6'h14;
	localparam logic [5:0] A_LPDIV = 6'h18;
	localparam logic [5:0] A_IMASK = 6'h1C;
	localparam logic [5:0] A_IRAW  = 6'h20;
	localparam logic [5:0] A_ICLR  = 6'h24;
	localparam logic [5:0] A_TIN   = 6'h28;
	localparam logic [5:0] A_TOUT  = 6'h2C;

	// Line register fields
	localparam int LN_WLEN  = 0;
	localparam int LN_PEN   = 2;
	localparam int LN_EVEN  = 3;
	localparam int LN_STOP2 = 4;
	localparam int LN_FEN   = 5;
	localparam int LN_BRK   = 6;

	// Control register fields
	localparam int CT_EN  = 0;
	localparam int CT_IR  = 1;
	localparam int CT_LP  = 2;
	localparam int CT_TST = 3;

	// Receive entry fields
	localparam int RE_FRM = 8;
	localparam int RE_PAR = 9;
	localparam int RE_BRK = 10;
	localparam int RE_OVR = 11;

	// Reset values
	localparam logic [15:0] DIVI_RST  = 16'h0001;
	localparam logic [5:0]  DIVF_RST  = 6'h00;
	localparam logic [6:0]  LINE_RST  = 7'h03;
	localparam logic [3:0]  CTRL_RST  = 4'h0;
	localparam logic [7:0]  LPDIV_RST = 8'h00;

	// Timing in oversample ticks; LP_PULSE in low-power ticks
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] IR_PULSE  = 4'h3;
	localparam logic [1:0] LP_PULSE  = 2'h3;
	localparam logic [3:0] MID_UART  = 4'h8;
	localparam logic [3:0] MID_IR    = 4'h4;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_st_t;

endpackage

// File: hw/asp_top.sv
// Serial port with x16 baud generator, queues and IR endec
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module asp_top
	import asp_pkg::*;
#(
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Register port
	input  wire logic [5:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Serial and IR pins
	input  wire logic        serial_rx_in,
	output logic             serial_tx_out,
	input  wire logic        ir_receive_in,
	output logic             ir_transmit_out_n,
	// Interrupts
	output logic             irq_rx,
	output logic             irq_tx,
	output logic             irq_err,
	output logic             irq_any
);
	localparam int AW = $clog2(DEPTH);
	typedef logic [AW-1:0] ptr_t;
	typedef logic [AW:0]   cnt_t;

	typedef struct packed {
		logic [31:0]             rdata;
		logic [15:0]             divi;
		logic [5:0]              divf;
		logic [6:0]              line;
		logic [3:0]              ctrl;
		logic [7:0]              lpdiv;
		logic [2:0]              imask;
		logic                    err_st;
		logic [5:0]              tout;
		logic [15:0]             bcnt;
		logic [5:0]              facc;
		logic                    tick;
		logic [7:0]              lpcnt;
		logic                    lptick;
		logic [DEPTH-1:0][7:0]   txm;
		ptr_t                    twp;
		ptr_t                    trp;
		cnt_t                    tcnt;
		logic [DEPTH-1:0][11:0]  rxm;
		ptr_t                    rwp;
		ptr_t                    rrp;
		cnt_t                    rcnt;
		asp_tx_st_t              tst;
		logic [6:0]              tcfg;
		logic [7:0]              tsh;
		logic [2:0]              tbit;
		logic [3:0]              ttk;
		logic                    tpar;
		logic                    txo;
		logic [1:0]              irp;
		logic [17:0]             dlow;
		logic                    dec;
		logic [3:0]              dtk;
		asp_rx_st_t              rst_q;
		logic [6:0]              rcfg;
		logic [3:0]              rtk;
		logic [7:0]              rsh;
		logic [2:0]              rbit;
		logic [2:0]              hist;
		logic                    rpar;
		logic                    rperr;
		logic                    rbrk;
		logic                    ovr;
		logic                    stx;
		logic                    iro;
		logic [3:0]              irq;
	} asp_state_t;

	asp_state_t s_ff;
	asp_state_t nxt_s;

	logic       fen;
	logic       ir;
	logic       lp;
	cnt_t       dep;
	logic       tx_full;
	logic       rx_full;
	logic       rx_empty;
	logic       tpush;
	logic       tpop;
	logic       rpush;
	logic       rpop;
	logic       carry;
	logic       rin;
	logic       maj;
	logic       ck;
	logic       tend;
	logic       bs;
	logic [7:0] mask;
	logic [7:0] rdat;
	logic [17:0] thr;
	logic [11:0] entry;

	always_comb begin
		nxt_s    = s_ff;
		fen      = s_ff.line[LN_FEN];
		ir       = s_ff.ctrl[CT_IR];
		lp       = s_ff.ctrl[CT_LP];
		dep      = fen ? cnt_t'(DEPTH) : cnt_t'(1);
		tx_full  = s_ff.tcnt >= dep;
		rx_full  = s_ff.rcnt >= dep;
		rx_empty = s_ff.rcnt == '0;
		tpush    = 1'b0;
		tpop     = 1'b0;
		rpush    = 1'b0;
		rpop     = 1'b0;
		carry    = 1'b0;
		bs       = 1'b0;
		entry    = '0;
		rdat     = '0;
		mask     = 8'hFF >> (2'd3 - s_ff.tcfg[LN_WLEN +: 2]);
		nxt_s.rdata = '0;

		// Register writes and reads
		if (reg_wr) begin
			case (reg_addr)
				A_DATA: if (!tx_full) begin
					nxt_s.txm[s_ff.twp] = reg_wdata[7:0];
					nxt_s.twp = s_ff.twp + ptr_t'(1);
					tpush = 1'b1;
				end
				A_DIVI:  nxt_s.divi  = reg_wdata[15:0];
				A_DIVF:  nxt_s.divf  = reg_wdata[5:0];
				A_LINE:  nxt_s.line  = reg_wdata[6:0];
				A_CTRL:  nxt_s.ctrl  = reg_wdata[3:0];
				A_LPDIV: nxt_s.lpdiv = reg_wdata[7:0];
				A_IMASK: nxt_s.imask = reg_wdata[2:0];
				A_ICLR:  if (reg_wdata[2]) nxt_s.err_st = 1'b0;
				A_TOUT:  nxt_s.tout  = reg_wdata[5:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				A_DATA: if (!rx_empty) begin
					nxt_s.rdata = {20'h0_0000, s_ff.rxm[s_ff.rrp]};
					nxt_s.rrp = s_ff.rrp + ptr_t'(1);
					rpop = 1'b1;
				end
				A_STAT:  nxt_s.rdata = {26'h000_0000, s_ff.ovr, s_ff.tcnt != '0 || s_ff.tst != TX_IDLE,
					tx_full, s_ff.tcnt == '0, rx_full, rx_empty};
				A_DIVI:  nxt_s.rdata = {16'h0000, s_ff.divi};
				A_DIVF:  nxt_s.rdata = {26'h000_0000, s_ff.divf};
				A_LINE:  nxt_s.rdata = {25'h000_0000, s_ff.line};
				A_CTRL:  nxt_s.rdata = {28'h000_0000, s_ff.ctrl};
				A_LPDIV: nxt_s.rdata = {24'h00_0000, s_ff.lpdiv};
				A_IMASK: nxt_s.rdata = {29'h000_0000, s_ff.imask};
				A_IRAW:  nxt_s.rdata = {29'h000_0000, s_ff.err_st, !tx_full, !rx_empty};
				A_TIN:   nxt_s.rdata = {30'h0000_0000, ir_receive_in, serial_rx_in};
				A_TOUT:  nxt_s.rdata = {26'h000_0000, s_ff.tout};
				default: ;
			endcase
		end

		// Baud divider with fractional accumulator
		nxt_s.tick = 1'b0;
		if (s_ff.divi != '0) begin
			if (s_ff.bcnt == '0) begin
				nxt_s.tick = 1'b1;
				{carry, nxt_s.facc} = {1'b0, s_ff.facc} + {1'b0, s_ff.divf};
				nxt_s.bcnt = s_ff.divi - 16'h0001 + {15'h0000, carry};
			end else begin
				nxt_s.bcnt = s_ff.bcnt - 16'h0001;
			end
		end
		nxt_s.lptick = 1'b0;
		if (s_ff.lpdiv != '0) begin
			if (s_ff.lpcnt == '0) begin
				nxt_s.lptick = 1'b1;
				nxt_s.lpcnt = s_ff.lpdiv - 8'h01;
			end else begin
				nxt_s.lpcnt = s_ff.lpcnt - 8'h01;
			end
		end

		// Transmitter
		tend = s_ff.tick && s_ff.ttk == TICK_LAST;
		if (s_ff.tick && s_ff.tst != TX_IDLE) begin
			nxt_s.ttk = s_ff.ttk + 4'h1;
		end
		case (s_ff.tst)
			TX_IDLE: if (s_ff.ctrl[CT_EN] && s_ff.tcnt != '0 && s_ff.tick) begin
				tpop = 1'b1;
				nxt_s.trp  = s_ff.trp + ptr_t'(1);
				nxt_s.tsh  = s_ff.txm[s_ff.trp];
				nxt_s.tcfg = s_ff.line;
				nxt_s.tpar = 1'b0;
				nxt_s.tbit = '0;
				nxt_s.ttk  = '0;
				nxt_s.txo  = 1'b0;
				nxt_s.tst  = TX_START;
				bs = 1'b1;
			end
			TX_START: if (tend) begin
				nxt_s.txo  = s_ff.tsh[0];
				nxt_s.tpar = (^(s_ff.tsh & mask)) ^ !s_ff.tcfg[LN_EVEN];
				nxt_s.tst  = TX_DATA;
				bs = 1'b1;
			end
			TX_DATA: if (tend) begin
				bs = 1'b1;
				if (s_ff.tbit == {1'b1, s_ff.tcfg[LN_WLEN +: 2]}) begin
					nxt_s.tst = s_ff.tcfg[LN_PEN] ? TX_PAR : TX_STOP;
					nxt_s.txo = s_ff.tcfg[LN_PEN] ? s_ff.tpar : 1'b1;
					nxt_s.tbit = '0;
				end else begin
					nxt_s.tsh  = s_ff.tsh >> 1;
					nxt_s.txo  = s_ff.tsh[1];
					nxt_s.tbit = s_ff.tbit + 3'h1;
				end
			end
			TX_PAR: if (tend) begin
				nxt_s.txo = 1'b1;
				nxt_s.tst = TX_STOP;
				bs = 1'b1;
			end
			TX_STOP: if (tend) begin
				if (s_ff.tcfg[LN_STOP2] && s_ff.tbit == '0) begin
					nxt_s.tbit = 3'h1;
				end else begin
					nxt_s.tst = TX_IDLE;
				end
			end
			default: nxt_s.tst = TX_IDLE;
		endcase
		nxt_s.tcnt = s_ff.tcnt + cnt_t'(tpush) - cnt_t'(tpop);

		// IR encoder pulse timing
		if (bs && !nxt_s.txo) begin
			nxt_s.irp = LP_PULSE;
		end else if (s_ff.lptick && s_ff.irp != '0) begin
			nxt_s.irp = s_ff.irp - 2'h1;
		end

		// IR decoder with glitch filter
		thr = lp ? (18'(s_ff.lpdiv) * 18'h0_0003) >> 4 : (18'(s_ff.divi) * 18'h0_0003) >> 4;
		if (ir_receive_in) begin
			nxt_s.dlow = '0;
		end else if (s_ff.dlow != 18'h3_FFFF) begin
			nxt_s.dlow = s_ff.dlow + 18'h0_0001;
		end
		if (!ir_receive_in && s_ff.dlow == thr) begin
			nxt_s.dec = 1'b0;
			nxt_s.dtk = '0;
		end else if (!s_ff.dec && s_ff.tick) begin
			nxt_s.dtk = s_ff.dtk + 4'h1;
			if (s_ff.dtk == TICK_LAST) nxt_s.dec = 1'b1;
		end

		// Receive source: IR path is half-duplex
		if (ir) begin
			rin = (s_ff.tst != TX_IDLE) ? 1'b1 : s_ff.dec;
		end else begin
			rin = serial_rx_in;
		end

		// Receiver with three-reading majority
		if (s_ff.tick) nxt_s.hist = {s_ff.hist[1:0], rin};
		maj = (s_ff.hist[1] & s_ff.hist[0]) | (s_ff.hist[1] & rin) | (s_ff.hist[0] & rin);
		if (s_ff.tick && s_ff.rst_q != RX_IDLE) nxt_s.rtk = s_ff.rtk + 4'h1;
		ck = s_ff.tick && (s_ff.rst_q == RX_START ?
			s_ff.rtk == (ir ? MID_IR : MID_UART) - 4'h1 : s_ff.rtk == TICK_LAST);
		rdat = s_ff.rsh >> (2'd3 - s_ff.rcfg[LN_WLEN +: 2]);
		case (s_ff.rst_q)
			RX_IDLE: if (s_ff.ctrl[CT_EN] && s_ff.tick && !rin) begin
				nxt_s.rst_q = RX_START;
				nxt_s.rtk  = '0;
				nxt_s.rcfg = s_ff.line;
			end
			RX_START: if (ck) begin
				nxt_s.rtk  = '0;
				nxt_s.rbit = '0;
				nxt_s.rpar = 1'b0;
				nxt_s.rbrk = 1'b1;
				nxt_s.rperr = 1'b0;
				nxt_s.rst_q = maj ? RX_IDLE : RX_DATA;
			end
			RX_DATA: if (ck) begin
				nxt_s.rtk  = '0;
				nxt_s.rsh  = {maj, s_ff.rsh[7:1]};
				nxt_s.rpar = s_ff.rpar ^ maj;
				nxt_s.rbrk = s_ff.rbrk & !maj;
				nxt_s.rbit = s_ff.rbit + 3'h1;
				if (s_ff.rbit == {1'b1, s_ff.rcfg[LN_WLEN +: 2]}) begin
					nxt_s.rst_q = s_ff.rcfg[LN_PEN] ? RX_PAR : RX_STOP;
				end
			end
			RX_PAR: if (ck) begin
				nxt_s.rtk   = '0;
				nxt_s.rperr = s_ff.rpar ^ maj ^ !s_ff.rcfg[LN_EVEN];
				nxt_s.rbrk  = s_ff.rbrk & !maj;
				nxt_s.rst_q = RX_STOP;
			end
			RX_STOP: if (ck) begin
				entry[7:0]    = rdat;
				entry[RE_FRM] = !maj;
				entry[RE_PAR] = s_ff.rperr;
				entry[RE_BRK] = s_ff.rbrk & !maj;
				entry[RE_OVR] = s_ff.ovr;
				if (rx_full) begin
					nxt_s.ovr = 1'b1;
				end else begin
					rpush = 1'b1;
					nxt_s.rxm[s_ff.rwp] = entry;
					nxt_s.rwp = s_ff.rwp + ptr_t'(1);
					nxt_s.ovr = 1'b0;
				end
				nxt_s.rst_q = RX_IDLE;
			end
			default: nxt_s.rst_q = RX_IDLE;
		endcase
		nxt_s.rcnt = s_ff.rcnt + cnt_t'(rpush) - cnt_t'(rpop);
		if (rx_full && ck && s_ff.rst_q == RX_STOP) nxt_s.err_st = 1'b1;
		if (rpush && (entry[RE_BRK:RE_FRM] != '0 || entry[RE_OVR])) nxt_s.err_st = 1'b1;

		// Output pins and interrupts
		nxt_s.stx = ir ? 1'b1 : (s_ff.line[LN_BRK] ? 1'b0 : s_ff.txo);
		nxt_s.iro = ir && (lp ? s_ff.irp != '0 :
			(s_ff.tst != TX_IDLE && !s_ff.txo && s_ff.ttk < IR_PULSE));
		nxt_s.irq[0] = s_ff.imask[0] && !rx_empty;
		nxt_s.irq[1] = s_ff.imask[1] && !tx_full;
		nxt_s.irq[2] = s_ff.imask[2] && s_ff.err_st;
		nxt_s.irq[3] = nxt_s.irq[0] || nxt_s.irq[1] || nxt_s.irq[2];
		if (s_ff.ctrl[CT_TST]) begin
			nxt_s.stx = s_ff.tout[0];
			nxt_s.iro = s_ff.tout[1];
			nxt_s.irq = s_ff.tout[5:2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_ff       <= '0;
			s_ff.divi  <= DIVI_RST;
			s_ff.divf  <= DIVF_RST;
			s_ff.line  <= LINE_RST;
			s_ff.ctrl  <= CTRL_RST;
			s_ff.lpdiv <= LPDIV_RST;
			s_ff.txo   <= 1'b1;
			s_ff.stx   <= 1'b1;
			s_ff.dec   <= 1'b1;
			s_ff.hist  <= 3'h7;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign reg_rdata         = s_ff.rdata;
	assign serial_tx_out     = s_ff.stx;
	assign ir_transmit_out_n = s_ff.iro;
	assign irq_rx            = s_ff.irq[0];
	assign irq_tx            = s_ff.irq[1];
	assign irq_err           = s_ff.irq[2];
	assign irq_any           = s_ff.irq[3];
endmodule
`default_nettype wire

// File: test/asp_props.sv
// Checker for register port, serial, IR and interrupt pin behaviour
`timescale 1ns/1ns
`default_nettype none
module asp_props
	import asp_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// Register port
	input wire logic [5:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Serial and IR pins
	input wire logic        serial_rx_in,
	input wire logic        serial_tx_out,
	input wire logic        ir_receive_in,
	input wire logic        ir_transmit_out_n,
	// Interrupts
	input wire logic        irq_rx,
	input wire logic        irq_tx,
	input wire logic        irq_err,
	input wire logic        irq_any
);
	logic       tst_ff;
	logic       ir_ff;
	logic [2:0] mask_ff;

	// Mirror of test, IR and mask settings
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tst_ff  <= 1'b0;
			ir_ff   <= 1'b0;
			mask_ff <= 3'h0;
		end else if (reg_wr && reg_addr == A_CTRL) begin
			tst_ff <= reg_wdata[CT_TST];
			ir_ff  <= reg_wdata[CT_IR];
		end else if (reg_wr && reg_addr == A_IMASK) begin
			mask_ff <= reg_wdata[2:0];
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_low16;
		(!serial_tx_out)[*8] ##1 (!serial_tx_out)[*8];
	endsequence
	sequence s_pulse3;
		ir_transmit_out_n[*3] ##1 !ir_transmit_out_n;
	endsequence
	property p_tout;
		reg_wr && reg_addr == A_TOUT && tst_ff |->
			##2 {ir_transmit_out_n, serial_tx_out} == $past(reg_wdata[1:0], 2);
	endproperty

	a_reset_quiet: assert property (disable iff (1'b0) rst |=> serial_tx_out && !ir_transmit_out_n && !irq_any && reg_rdata == 32'h0)
		else $error("outputs not quiet after reset");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property (reg_rd && reg_addr > A_TOUT |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_tin_raw: assert property (reg_rd && reg_addr == A_TIN |=> reg_rdata == {30'h0, $past(ir_receive_in), $past(serial_rx_in)})
		else $error("input readback wrong");
	a_tout_drive: assert property (p_tout)
		else $error("test output not driven");
	a_bit_width: assert property ($fell(serial_tx_out) && !tst_ff && !$past(tst_ff) |-> s_low16)
		else $error("low bit shorter than sixteen ticks");
	a_ir_pulse3: assert property ($rose(ir_transmit_out_n) && !tst_ff && !$past(tst_ff) |-> s_pulse3)
		else $error("IR pulse not three ticks");
	a_ir_tx_high: assert property (ir_ff && $past(ir_ff, 2) && !tst_ff |-> serial_tx_out)
		else $error("serial out not high in IR mode");
	a_irq_or: assert property (!tst_ff && !$past(tst_ff) |-> irq_any == (irq_rx | irq_tx | irq_err))
		else $error("combined interrupt not OR");
	a_irq_mask: assert property (!tst_ff && !$past(tst_ff) |-> ({irq_err, irq_tx, irq_rx} & ~$past(mask_ff)) == 3'h0)
		else $error("masked interrupt raised");
endmodule

bind asp_top asp_props u_props (
	.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
	.ir_receive_in(ir_receive_in), .ir_transmit_out_n(ir_transmit_out_n), .irq_rx(irq_rx),
	.irq_tx(irq_tx), .irq_err(irq_err), .irq_any(irq_any)
);
`default_nettype wire

// File: test/asp_peer.sv
// Remote serial and IR peer sending and catching frames
`timescale 1ns/1ns
`default_nettype none
module asp_peer (
	// Clock
	input  wire logic clk_sys,
	// Lines
	input  wire logic serial_tx_out,
	output logic      serial_rx_in,
	output logic      ir_receive_in
);
	initial begin
		serial_rx_in  = 1'b1;
		ir_receive_in = 1'b1;
	end

	// Frame of sixteen ticks per bit, IR zero as three-tick low pulse
	task automatic send(input logic [7:0] d, input logic ir, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			for (int c = 0; c < 16; c++) begin
				@(posedge clk_sys);
				if (ir)
					ir_receive_in <= f[i] | (c > 2);
				else
					serial_rx_in <= f[i] | (i == 9 && c > 11);
			end
		end
		@(posedge clk_sys);
		serial_rx_in  <= 1'b1;
		ir_receive_in <= 1'b1;
	endtask

	// Catch data and one following bit at mid-bit
	task automatic catch(output logic [8:0] v);
		for (int n = 0; n < 300 && serial_tx_out; n++)
			@(posedge clk_sys);
		repeat (8) @(posedge clk_sys);
		for (int i = 0; i < 9; i++) begin
			repeat (16) @(posedge clk_sys);
			v[i] = serial_tx_out;
		end
		// Stop at bit end so a back-to-back start is seen
		repeat (8) @(posedge clk_sys);
	endtask

	task automatic set_lines(input logic [1:0] v);
		@(posedge clk_sys);
		{ir_receive_in, serial_rx_in} <= v;
	endtask
endmodule
`default_nettype wire

// File: test/asp_top_tb.sv
// Self-checking bench for the serial port with IR endec
`timescale 1ns/1ns
`default_nettype none
module asp_top_tb;
	import asp_pkg::*;
	logic        clk_sys, rst, reg_wr, reg_rd;
	logic [5:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d, e;
	logic        serial_rx_in, serial_tx_out, ir_receive_in, ir_transmit_out_n;
	logic        irq_rx, irq_tx, irq_err, irq_any;
	logic [8:0]  v;
	logic [7:0]  cfg [4] = '{8'h03, 8'h07, 8'h0F, 8'h33};
	integer      seed, bad_count, compares, hi, lo;

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	asp_top #(.DEPTH(32)) u_dut (
		.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
		.ir_receive_in(ir_receive_in), .ir_transmit_out_n(ir_transmit_out_n), .irq_rx(irq_rx),
		.irq_tx(irq_tx), .irq_err(irq_err), .irq_any(irq_any));
	asp_peer u_peer (.clk_sys(clk_sys), .serial_tx_out(serial_tx_out), .serial_rx_in(serial_rx_in),
		.ir_receive_in(ir_receive_in));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] w);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= w;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	// Expected bit after data for each line setting
	function automatic logic after_bit(input int k, input logic [7:0] b);
		return (k == 1) ? ~^b : (k == 2) ? ^b : 1'b1;
	endfunction

	function automatic int zeros(input logic [7:0] b);
		int n;
		n = 1;
		for (int i = 0; i < 8; i++)
			n += !b[i];
		return n;
	endfunction

	task automatic tally_and_finish();
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk_sys);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		seed = 84440;
		bad_count = 0;
		compares = 0;
		{rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 40'h0};
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rdchk(A_DIVI, 32'h0000_0001);
		rdchk(A_LINE, 32'h0000_0003);
		rdchk(A_CTRL, 32'h0000_0000);
		rdchk(6'h30, 32'h0000_0000);
		wr(A_CTRL, 32'h0000_0001);
		for (int k = 0; k < 4; k++) begin
			d = $random(seed);
			wr(A_LINE, {24'h0, cfg[k]});
			wr(A_DATA, d);
			u_peer.catch(v);
			chk({23'h0, v}, {23'h0, after_bit(k, d[7:0]), d[7:0]});
		end
		d = $random(seed);
		wr(A_LINE, 32'h0000_0023);
		wr(A_DATA, d);
		wr(A_DATA, d >> 8);
		u_peer.catch(v);
		chk({23'h0, v}, {24'h1, d[7:0]});
		u_peer.catch(v);
		chk({23'h0, v}, {24'h1, d[15:8]});
		wr(A_LINE, 32'h0000_0003);
		wr(A_IMASK, 32'h0000_0005);
		d = $random(seed) & 32'h0000_00FF;
		u_peer.send(d, 1'b0, 1'b1);
		repeat (4) @(posedge clk_sys);
		chk(irq_rx, 1);
		chk(irq_any, 1);
		rdchk(A_DATA, d);
		repeat (2) @(posedge clk_sys);
		chk(irq_any, 0);
		u_peer.send(d, 1'b0, 1'b0);
		rdchk(A_DATA, d | 32'h0000_0100 | ((d == 32'h0) ? 32'h0000_0400 : 32'h0));
		chk(irq_err, 1);
		u_peer.send(8'h00, 1'b0, 1'b0);
		rdchk(A_DATA, 32'h0000_0500);
		wr(A_ICLR, 32'h0000_0004);
		repeat (2) @(posedge clk_sys);
		chk(irq_err, 0);
		e = $random(seed) & 32'h0000_FFFF;
		u_peer.send(e[7:0], 1'b0, 1'b1);
		u_peer.send(e[15:8], 1'b0, 1'b1);
		rdchk(A_DATA, {24'h0, e[7:0]});
		u_peer.send(d, 1'b0, 1'b1);
		rdchk(A_DATA, d | 32'h0000_0800);
		wr(A_CTRL, 32'h0000_0003);
		d = $random(seed);
		wr(A_DATA, d);
		hi = 0;
		lo = 0;
		repeat (200) begin
			@(posedge clk_sys);
			hi += ir_transmit_out_n;
			lo += !serial_tx_out;
		end
		chk(hi, 3 * zeros(d[7:0]));
		chk(lo, 0);
		d = $random(seed) & 32'h0000_00FF;
		u_peer.send(d, 1'b1, 1'b1);
		rdchk(A_DATA, d);
		u_peer.send(d, 1'b0, 1'b1);
		rdchk(A_DATA, 32'h0000_0000);
		wr(A_CTRL, 32'h0000_0008);
		u_peer.set_lines(2'b01);
		rdchk(A_TIN, 32'h0000_0001);
		wr(A_TOUT, 32'h0000_0022);
		repeat (3) @(posedge clk_sys);
		chk({ir_transmit_out_n, serial_tx_out}, 2'b10);
		chk(irq_any, 1);
		u_peer.set_lines(2'b11);
		wr(A_CTRL, 32'h0000_0000);
		wr(A_IMASK, 32'h0000_0002);
		wr(A_LPDIV, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		chk(irq_tx, 1);
		chk(irq_any, 1);
		wr(A_CTRL, 32'h0000_0007);
		d = $random(seed);
		wr(A_DATA, d);
		hi = 0;
		lo = 0;
		repeat (200) begin
			@(posedge clk_sys);
			hi += ir_transmit_out_n;
			lo += !serial_tx_out;
		end
		chk(hi, 3 * zeros(d[7:0]));
		chk(lo, 0);
		wr(A_CTRL, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
